// File: hdl/dcrd_decoder.sv
// Behaviour
// - BE3D: delayed call via sum register, 2 cycles
// - 7A80 form: two-word call, index update, 4 cycles
// - 7E80 form: delayed two-word call, 2 cycles
// - E800 form: conditional call, 2 or 4 cycles
// - F800 form: delayed conditional call, 2 cycles
// - BE70 form: software trap to numbered vector, 4
// - BE52: software nonmaskable interrupt, 4 cycles
// - EF00: subroutine exit, 4 cycles
// - EC00 form: conditional exit, 2 or 4
// - FC00 form: delayed conditional exit, 2 cycles
// - FF00: delayed subroutine exit, 2 cycles
// - BE3A: interrupt exit re-enabling maskable interrupts
`timescale 1ns/10ps
`default_nettype none
`include "dcrd_params.svh"

module dcrd_decoder #(
	parameter int STACK_DEPTH = 8
) (
	input wire logic CLK,
	input wire logic SYS_RST,
	input wire logic INSTR_VALID,
	input wire logic [15:0] INSTR_WORD,
	input wire logic [15:0] INSTR_PC,
	input wire logic [15:0] SUM_REG,
	input wire dcrd_pkg::dcrd_flags_s FLAGS,
	output logic BUSY,
	output logic DONE,
	output logic [1:0] WORD_COUNT,
	output logic [2:0] CYCLE_COUNT,
	output dcrd_pkg::dcrd_action_s ACTION,
	output logic ACTION_VALID,
	output logic [15:0] STACK_TOP,
	output logic STACK_OVERFLOW,
	output logic STACK_UNDERFLOW
);
	import dcrd_pkg::*;

	// ----------------------------------------
	// Elaboration checks
	// ----------------------------------------
	if (STACK_DEPTH < 2 || STACK_DEPTH > 256) begin : g_depth_bad
		$error("STACK_DEPTH out of range");
	end

	localparam int PW = $clog2(STACK_DEPTH + 1);

	// ----------------------------------------
	// Decode functions
	// ----------------------------------------
	// Pattern match used for each opcode family
	function automatic logic op_hit(input logic [15:0] w, input logic [15:0] m, input logic [15:0] p);
		op_hit = ((w & m) == p);
	endfunction

	// Condition evaluation: TP picks the tc test (tc set, tc clear or none), FLAG_TEST_MASK masks flags
	function automatic logic cond_true(input logic [15:0] w, input dcrd_flags_s f);
		logic [3:0] tst;
		logic [3:0] val;
		logic tp_ok;
		tst = w[7:4];
		val = w[3:0];
		case (w[9:8])
			2'b00: tp_ok = 1'b1;
			2'b01: tp_ok = f.tc;
			2'b10: tp_ok = ~f.tc;
			default: tp_ok = 1'b1;
		endcase
		// Each tested flag must equal its wanted value; untested flags ignored
		cond_true = tp_ok && (((({f.zero, f.less, f.ovf, f.carry}) ^ val) & tst) == 4'h0);
	endfunction

	// ----------------------------------------
	// Combinational classification
	// ----------------------------------------
	dcrd_class_e cls; // Class of the presented word
	assign cls = (INSTR_WORD == `DCRD_OP_CALL_SUM_D) ? DCRD_CALL_SUM_D :
		(INSTR_WORD == `DCRD_OP_NMI) ? DCRD_NMI :
		(INSTR_WORD == `DCRD_OP_INT_EXIT) ? DCRD_INT_EXIT :
		(INSTR_WORD == `DCRD_OP_EXIT) ? DCRD_EXIT :
		(INSTR_WORD == `DCRD_OP_EXIT_D) ? DCRD_EXIT_D :
		op_hit(INSTR_WORD, `DCRD_MSK_AR, `DCRD_OP_CALL) ? DCRD_CALL :
		op_hit(INSTR_WORD, `DCRD_MSK_AR, `DCRD_OP_CALL_D) ? DCRD_CALL_D :
		op_hit(INSTR_WORD, `DCRD_MSK_TRAP, `DCRD_OP_TRAP) ? DCRD_TRAP :
		op_hit(INSTR_WORD, `DCRD_MSK_COND, `DCRD_OP_CCALL) ? DCRD_CCALL :
		op_hit(INSTR_WORD, `DCRD_MSK_COND, `DCRD_OP_CCALL_D) ? DCRD_CCALL_D :
		op_hit(INSTR_WORD, `DCRD_MSK_COND, `DCRD_OP_CEXIT_D) ? DCRD_CEXIT_D :
		op_hit(INSTR_WORD, `DCRD_MSK_COND, `DCRD_OP_CEXIT) ? DCRD_CEXIT :
		DCRD_NONE;

	// Two-word forms need the operand word as the target
	wire two_word = (cls == DCRD_CALL) || (cls == DCRD_CALL_D) || (cls == DCRD_CCALL) || (cls == DCRD_CCALL_D);
	wire is_cond = (cls == DCRD_CCALL) || (cls == DCRD_CCALL_D) || (cls == DCRD_CEXIT) || (cls == DCRD_CEXIT_D);
	wire is_delayed = (cls == DCRD_CALL_SUM_D) || (cls == DCRD_CALL_D) || (cls == DCRD_CCALL_D) ||
		(cls == DCRD_CEXIT_D) || (cls == DCRD_EXIT_D);
	wire is_pushing = (cls == DCRD_CALL_SUM_D) || (cls == DCRD_CALL) || (cls == DCRD_CALL_D) ||
		(cls == DCRD_CCALL) || (cls == DCRD_CCALL_D) || (cls == DCRD_TRAP) || (cls == DCRD_NMI);
	wire is_popping = (cls == DCRD_EXIT) || (cls == DCRD_CEXIT) || (cls == DCRD_CEXIT_D) ||
		(cls == DCRD_EXIT_D) || (cls == DCRD_INT_EXIT);
	wire cond_ok = ~is_cond || cond_true(INSTR_WORD, FLAGS); // Unconditional forms always transfer

	// Cycle length: delayed forms 2, conditional non-delayed 2 or 4, rest 4
	wire [2:0] cyc_len = is_delayed ? `DCRD_CYC_SHORT :
		(is_cond && !cond_ok) ? `DCRD_CYC_SHORT :
		`DCRD_CYC_LONG;

	// Trap vector: NMI uses a fixed high trap number
	// Software traps carry a four-bit number, so number 31 can never collide with them
	wire [4:0] trap_num = (cls == DCRD_NMI) ? `DCRD_NMI_TRAP_NUM : {1'b0, INSTR_WORD[3:0]};
	wire [15:0] trap_vec = 16'(trap_num) * 16'(`DCRD_VEC_STRIDE);

	// Return address skips the operand word of two-word forms
	wire [15:0] ret_addr = INSTR_PC + (two_word ? 16'h0002 : 16'h0001);

	// ----------------------------------------
	// Sequencer registers
	// ----------------------------------------
	dcrd_state_e state_q, state_d; // Sequencer state
	logic [15:0] ret_q; // Return address to push
	logic [2:0] cnt_q, cnt_d; // Cycles remaining of execution
	logic [2:0] len_q; // Length latched for reporting
	logic busy_q, done_q;
	logic [1:0] words_q;
	dcrd_action_s act_q, act_d;
	logic act_v_q, act_v_d;

	// Hardware return stack, array with pointer
	logic [15:0] stack_mem [STACK_DEPTH];
	logic [PW-1:0] sp_q;
	logic ovf_q, unf_q;
	logic [15:0] top_q;

	wire accept = INSTR_VALID && (state_q == DCRD_ST_IDLE) && (cls != DCRD_NONE);
	wire operand = INSTR_VALID && (state_q == DCRD_ST_WORD2);
	wire stack_full = (sp_q == PW'(STACK_DEPTH));
	wire stack_empty = (sp_q == '0);

	// ----------------------------------------
	// Next-state and action selection
	// ----------------------------------------
	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		act_d = act_q;
		act_v_d = 1'b0;
		case (state_q)
			DCRD_ST_IDLE: begin
				if (accept) begin
					// Single-word forms issue their action now
					act_d = '0;
					act_d.delayed = is_delayed;
					act_d.push = is_pushing && cond_ok;
					act_d.pop = is_popping && cond_ok;
					act_d.load_pc = cond_ok;
					act_d.target = (cls == DCRD_CALL_SUM_D) ? SUM_REG : trap_vec;
					act_d.int_enable = (cls == DCRD_INT_EXIT);
					act_d.ar_update = (cls == DCRD_CALL) || (cls == DCRD_CALL_D);
					act_d.ar_field = INSTR_WORD[6:0];
					act_v_d = ~two_word;
					cnt_d = cyc_len - 3'h1;
					state_d = two_word ? DCRD_ST_WORD2 : DCRD_ST_EXEC;
				end
			end
			DCRD_ST_WORD2: begin
				// Operand word is the call target
				if (operand) begin
					act_d.target = INSTR_WORD;
					act_v_d = 1'b1;
					state_d = DCRD_ST_EXEC;
				end
			end
			DCRD_ST_EXEC: begin
				if (cnt_q <= 3'h1) begin
					state_d = DCRD_ST_IDLE;
				end
				cnt_d = cnt_q - 3'h1;
			end
			default: begin
				state_d = DCRD_ST_IDLE;
			end
		endcase
	end

	// ----------------------------------------
	// Sequencer flops
	// ----------------------------------------
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			state_q <= DCRD_ST_IDLE;
			cnt_q <= 3'h0;
			act_q <= '0;
			act_v_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			act_q <= act_d;
			act_v_q <= act_v_d;
		end
	end

	// Latched facts about the accepted instruction
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			ret_q <= 16'h0000;
			len_q <= 3'h0;
			words_q <= 2'h0;
		end else if (accept) begin
			ret_q <= ret_addr;
			len_q <= cyc_len;
			words_q <= two_word ? 2'h2 : 2'h1;
		end
	end

	// Busy across the whole instruction; done is registered and pulses in the same cycle that busy falls
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			busy_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			busy_q <= (state_d != DCRD_ST_IDLE);
			done_q <= (state_q == DCRD_ST_EXEC) && (cnt_q <= 3'h1);
		end
	end

	// ----------------------------------------
	// Return stack
	// ----------------------------------------
	// Push saturates at full and pop at empty; faults are sticky until reset
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			sp_q <= '0;
			ovf_q <= 1'b0;
			unf_q <= 1'b0;
		end else if (act_v_d && act_d.push) begin
			if (stack_full) begin
				ovf_q <= 1'b1;
			end else begin
				sp_q <= sp_q + PW'(1);
			end
		end else if (act_v_d && act_d.pop) begin
			if (stack_empty) begin
				unf_q <= 1'b1;
			end else begin
				sp_q <= sp_q - PW'(1);
			end
		end
	end

	// Storage has no reset; only the pointer marks valid entries
	always_ff @(posedge CLK) begin
		if (act_v_d && act_d.push && !stack_full) begin
			stack_mem[sp_q[PW-1:0] % STACK_DEPTH] <= (state_q == DCRD_ST_WORD2) ? ret_q : ret_addr;
		end
	end

	// Popped value is the new program counter target
	wire [15:0] pop_val = stack_empty ? 16'h0000 : stack_mem[(sp_q - PW'(1)) % STACK_DEPTH];
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			top_q <= 16'h0000;
		end else if (act_v_d && act_d.pop) begin
			top_q <= pop_val;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign BUSY = busy_q;
	assign DONE = done_q;
	assign WORD_COUNT = words_q;
	assign CYCLE_COUNT = len_q;
	assign ACTION = act_q;
	assign ACTION_VALID = act_v_q;
	assign STACK_TOP = top_q;
	assign STACK_OVERFLOW = ovf_q;
	assign STACK_UNDERFLOW = unf_q;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_sum_call_len: assert property (@(posedge CLK) disable iff (SYS_RST)
		accept && cls == DCRD_CALL_SUM_D |=> len_q == 3'h2 && ACTION.delayed)
		else $error("sum call length wrong");
	a_call_len: assert property (@(posedge CLK) disable iff (SYS_RST)
		accept && cls == DCRD_CALL |=> len_q == 3'h4 && words_q == 2'h2)
		else $error("call length wrong");
	a_call_d_len: assert property (@(posedge CLK) disable iff (SYS_RST)
		accept && cls == DCRD_CALL_D |=> len_q == 3'h2 && words_q == 2'h2)
		else $error("delayed call length wrong");
	a_ccall_len: assert property (@(posedge CLK) disable iff (SYS_RST)
		accept && cls == DCRD_CCALL |=> len_q == (cond_true($past(INSTR_WORD), $past(FLAGS)) ? 3'h4 : 3'h2))
		else $error("cond call length wrong");
	a_ccall_d_len: assert property (@(posedge CLK) disable iff (SYS_RST)
		accept && cls == DCRD_CCALL_D |=> len_q == 3'h2)
		else $error("delayed cond call length wrong");
	a_trap_vec: assert property (@(posedge CLK) disable iff (SYS_RST)
		accept && cls == DCRD_TRAP |=> ACTION_VALID && ACTION.push && ACTION.target == {$past(INSTR_WORD[3:0]), 1'b0} + 16'h0000)
		else $error("trap vector wrong");
	a_nmi_len: assert property (@(posedge CLK) disable iff (SYS_RST)
		accept && cls == DCRD_NMI |=> len_q == 3'h4 ##3 DONE)
		else $error("nmi timing wrong");
	a_exit_pop: assert property (@(posedge CLK) disable iff (SYS_RST)
		accept && cls == DCRD_EXIT |=> ACTION.pop && len_q == 3'h4)
		else $error("exit wrong");
	a_cexit_len: assert property (@(posedge CLK) disable iff (SYS_RST)
		accept && cls == DCRD_CEXIT && !cond_ok |=> len_q == 3'h2 && !ACTION.pop)
		else $error("cond exit false path wrong");
	a_cexit_d_len: assert property (@(posedge CLK) disable iff (SYS_RST)
		accept && cls == DCRD_CEXIT_D |=> len_q == 3'h2 ##1 DONE)
		else $error("delayed cond exit wrong");
	a_exit_d_len: assert property (@(posedge CLK) disable iff (SYS_RST)
		accept && cls == DCRD_EXIT_D |=> ACTION.delayed && ACTION.pop ##1 DONE)
		else $error("delayed exit wrong");
	a_int_exit_en: assert property (@(posedge CLK) disable iff (SYS_RST)
		accept && cls == DCRD_INT_EXIT |=> ACTION_VALID && ACTION.int_enable && ACTION.pop)
		else $error("interrupt exit enable missing");

endmodule
`default_nettype wire

// File: hdl/dcrd_params.svh
`ifndef DCRD_PARAMS_SVH
`define DCRD_PARAMS_SVH

// ----------------------------------------
// Opcode patterns and masks
// ----------------------------------------
`define DCRD_OP_CALL_SUM_D 16'hBE3D
`define DCRD_OP_NMI 16'hBE52
`define DCRD_OP_EXIT 16'hEF00
`define DCRD_OP_EXIT_D 16'hFF00
`define DCRD_OP_INT_EXIT 16'hBE3A
`define DCRD_MSK_AR 16'hFF80
`define DCRD_OP_CALL 16'h7A80
`define DCRD_OP_CALL_D 16'h7E80
`define DCRD_MSK_COND 16'hFC00
`define DCRD_OP_CCALL 16'hE800
`define DCRD_OP_CCALL_D 16'hF800
`define DCRD_OP_CEXIT 16'hEC00
`define DCRD_OP_CEXIT_D 16'hFC00
`define DCRD_MSK_TRAP 16'hFFF0
`define DCRD_OP_TRAP 16'hBE70

// ----------------------------------------
// Execution lengths in cycles
// ----------------------------------------
`define DCRD_CYC_SHORT 3'h2
`define DCRD_CYC_LONG 3'h4

// ----------------------------------------
// Vector table
// ----------------------------------------
`define DCRD_VEC_STRIDE 2
`define DCRD_NMI_TRAP_NUM 5'h1F

`endif

// File: hdl/dcrd_pkg.sv
`default_nettype none

package dcrd_pkg;

	// Instruction classes recognised by the decoder
	typedef enum logic [3:0] {
		DCRD_NONE = 4'h0,
		DCRD_CALL_SUM_D = 4'h1,
		DCRD_CALL = 4'h2,
		DCRD_CALL_D = 4'h3,
		DCRD_CCALL = 4'h4,
		DCRD_CCALL_D = 4'h5,
		DCRD_TRAP = 4'h6,
		DCRD_NMI = 4'h7,
		DCRD_EXIT = 4'h8,
		DCRD_CEXIT = 4'h9,
		DCRD_CEXIT_D = 4'hA,
		DCRD_EXIT_D = 4'hB,
		DCRD_INT_EXIT = 4'hC
	} dcrd_class_e;

	// Sequencer states, Gray coded along idle -> fetch2 -> exec
	typedef enum logic [1:0] {
		DCRD_ST_IDLE = 2'b00,
		DCRD_ST_WORD2 = 2'b01,
		DCRD_ST_EXEC = 2'b11
	} dcrd_state_e;

	// Core status flags tested by the condition field
	typedef struct packed {
		logic zero;
		logic less;
		logic ovf;
		logic carry;
		logic tc;
	} dcrd_flags_s;

	// Control action handed to the program sequencer
	typedef struct packed {
		logic push;
		logic pop;
		logic load_pc;
		logic [15:0] target;
		logic ar_update;
		logic [6:0] ar_field;
		logic int_enable;
		logic delayed;
	} dcrd_action_s;

endpackage
`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Self-checking bench for the call and exit decoder
// ----------------------------------------
module testbench;
	import dcrd_pkg::*;
	logic CLK = 1'b0; // Core clock, 40 ns period
	logic SYS_RST = 1'b1; // Held for the first 4 edges
	logic INSTR_VALID = 1'b0;
	logic [15:0] INSTR_WORD = 16'h0000;
	logic [15:0] INSTR_PC = 16'h0000;
	logic [15:0] SUM_REG = 16'h0000;
	dcrd_flags_s FLAGS = '0;
	logic BUSY, DONE, ACTION_VALID, STACK_OVERFLOW, STACK_UNDERFLOW;
	logic [1:0] WORD_COUNT;
	logic [2:0] CYCLE_COUNT;
	logic [15:0] STACK_TOP;
	dcrd_action_s ACTION;
	int bad_count = 0; // Mismatches seen
	int n_checks = 0; // Comparisons made
	int av_count = 0; // Action pulses counted on the port
	int n_instr = 0; // Instructions the model expects to be taken
	logic [31:0] seed = 32'h5624; // Xorshift state, fixed start
	logic [16:0] stk[$]; // Model stack; bit 16 marks a delayed push, whose slot offset is left unchecked

	always #20 CLK = ~CLK;

	dcrd_decoder uut (
		.CLK(CLK),
		.SYS_RST(SYS_RST),
		.INSTR_VALID(INSTR_VALID),
		.INSTR_WORD(INSTR_WORD),
		.INSTR_PC(INSTR_PC),
		.SUM_REG(SUM_REG),
		.FLAGS(FLAGS),
		.BUSY(BUSY),
		.DONE(DONE),
		.WORD_COUNT(WORD_COUNT),
		.CYCLE_COUNT(CYCLE_COUNT),
		.ACTION(ACTION),
		.ACTION_VALID(ACTION_VALID),
		.STACK_TOP(STACK_TOP),
		.STACK_OVERFLOW(STACK_OVERFLOW),
		.STACK_UNDERFLOW(STACK_UNDERFLOW)
	);

	// Every pulse counts, so refused or unknown words show up as extras
	always @(posedge CLK) begin
		if (ACTION_VALID === 1'b1) av_count++;
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// Condition: type select on tc, then masked flag compare
	function automatic logic cond_ok(logic [15:0] w, dcrd_flags_s f);
		logic t;
		t = (w[9:8] == 2'b01) ? f.tc : (w[9:8] == 2'b10) ? !f.tc : 1'b1;
		return t && ((({f.zero, f.less, f.ovf, f.carry} ^ w[3:0]) & w[7:4]) == 4'h0);
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Bounded wait for the action pulse or the done pulse
	task automatic wait_for(input bit want_done);
		int i;
		#1;
		for (i = 0; i < 12; i++) begin
			if ((want_done ? DONE : ACTION_VALID) === 1'b1) return;
			@(posedge CLK) #1;
		end
		bad_count++;
		finish_test();
	endtask

	// ----------------------------------------
	// One random instruction, checked against the model
	// ----------------------------------------
	task automatic run_one();
		logic [31:0] r, r2;
		logic [15:0] w, w2, pc, sr, tgt, cf;
		logic [16:0] e;
		logic [4:0] wc;
		dcrd_flags_s f;
		dcrd_class_e k;
		logic c, two, dly, psh, pop;
		logic [2:0] cyc;
		r = rnd();
		r2 = rnd();
		w2 = r2[15:0];
		f = dcrd_flags_s'(r2[20:16]);
		pc = r[31:16];
		sr = r[15:0] ^ r2[31:16];
		k = dcrd_class_e'(r[27:24] % 4'hC + 4'h1);
		// Keep the model stack inside the default depth of 8
		if (k >= DCRD_EXIT && stk.size() == 0) k = DCRD_TRAP;
		if (k < DCRD_EXIT && stk.size() > 5) k = DCRD_EXIT;
		cf = {6'h00, (r[9:8] == 2'b11) ? 2'b00 : r[9:8], r[7:0]};
		case (k)
			DCRD_CALL_SUM_D: w = 16'hBE3D;
			DCRD_CALL: w = 16'h7A80 | {9'h000, r[6:0]};
			DCRD_CALL_D: w = 16'h7E80 | {9'h000, r[6:0]};
			DCRD_CCALL: w = 16'hE800 | cf;
			DCRD_CCALL_D: w = 16'hF800 | cf;
			DCRD_TRAP: w = 16'hBE70 | {12'h000, r[3:0]};
			DCRD_NMI: w = 16'hBE52;
			DCRD_EXIT: w = 16'hEF00;
			DCRD_CEXIT: w = 16'hEC00 | cf;
			DCRD_CEXIT_D: w = 16'hFC00 | cf;
			DCRD_EXIT_D: w = 16'hFF00;
			default: w = 16'hBE3A;
		endcase
		two = k inside {DCRD_CALL, DCRD_CALL_D, DCRD_CCALL, DCRD_CCALL_D};
		dly = k inside {DCRD_CALL_SUM_D, DCRD_CALL_D, DCRD_CCALL_D, DCRD_CEXIT_D, DCRD_EXIT_D};
		c = !(k inside {DCRD_CCALL, DCRD_CCALL_D, DCRD_CEXIT, DCRD_CEXIT_D}) || cond_ok(w, f);
		psh = c && k < DCRD_EXIT;
		pop = c && k >= DCRD_EXIT;
		cyc = (dly || !c) ? 3'h2 : 3'h4;
		tgt = (k == DCRD_CALL_SUM_D) ? sr : (k == DCRD_TRAP) ? {11'h000, w[3:0], 1'b0} : (k == DCRD_NMI) ? 16'h003E : w2;
		INSTR_VALID <= 1'b1;
		INSTR_WORD <= w;
		INSTR_PC <= pc;
		SUM_REG <= sr;
		FLAGS <= f;
		@(posedge CLK);
		// Second word carries the call target
		if (two) begin
			INSTR_WORD <= w2;
			@(posedge CLK);
		end
		INSTR_VALID <= 1'b0;
		n_instr++;
		wait_for(1'b0);
		chk(BUSY, 1'b1);
		wc = {WORD_COUNT, CYCLE_COUNT};
		case (k)
			DCRD_CALL_SUM_D: chk(wc, {2'd1, cyc});
			DCRD_CALL: chk(wc, {2'd2, cyc});
			DCRD_CALL_D: chk(wc, {2'd2, cyc});
			DCRD_CCALL: chk(wc, {2'd2, cyc});
			DCRD_CCALL_D: chk(wc, {2'd2, cyc});
			DCRD_TRAP: chk(wc, {2'd1, cyc});
			DCRD_NMI: chk(wc, {2'd1, cyc});
			DCRD_EXIT: chk(wc, {2'd1, cyc});
			DCRD_CEXIT: chk(wc, {2'd1, cyc});
			DCRD_CEXIT_D: chk(wc, {2'd1, cyc});
			DCRD_EXIT_D: chk(wc, {2'd1, cyc});
			default: chk(WORD_COUNT, 2'd1);
		endcase
		chk(ACTION.int_enable, k == DCRD_INT_EXIT);
		chk(ACTION.load_pc, c);
		chk(ACTION.delayed, dly);
		chk({ACTION.push, ACTION.pop}, {psh, pop});
		if (psh) chk(ACTION.target, tgt);
		if (k inside {DCRD_CALL, DCRD_CALL_D}) chk({ACTION.ar_update, ACTION.ar_field}, {1'b1, w[6:0]});
		// A word offered while a long instruction runs must be dropped
		if (cyc == 3'h4) begin
			@(posedge CLK);
			INSTR_VALID <= 1'b1;
			INSTR_WORD <= 16'hEF00;
			@(posedge CLK);
			INSTR_VALID <= 1'b0;
		end
		if (psh) stk.push_back({dly, pc + (two ? 16'd2 : 16'd1)});
		wait_for(1'b1);
		chk(BUSY, 1'b0);
		if (pop) begin
			e = stk.pop_back();
			if (!e[16]) chk(STACK_TOP, e[15:0]);
		end
		@(posedge CLK);
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (4) @(posedge CLK);
		SYS_RST <= 1'b0;
		@(posedge CLK);
		// Unknown word zero must not produce an action
		INSTR_VALID <= 1'b1;
		@(posedge CLK);
		INSTR_VALID <= 1'b0;
		@(posedge CLK);
		repeat (300) run_one();
		repeat (4) @(posedge CLK);
		chk(av_count, n_instr);
		chk({STACK_OVERFLOW, STACK_UNDERFLOW}, 2'b00);
		finish_test();
	end
endmodule
`default_nettype wire
